// *** core/sci_exec.sv ***
// System-control instruction executor: program counter, stack pointer,
// work register, global interrupt enable, halt and reset controls.
// Assumes a decoded opcode from the fetch stage on the same clock, and a
// stack memory whose read data is valid in the cycle of the read strobe.

`timescale 1ns/10ps

module sci_exec
  import sci_pkg::*;
#(
  parameter int PC_W = SCI_PC_W_DEF
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire sci_op_type instr_op_i,
  input wire logic [PC_W-1:0] instr_target_i,
  input wire logic [SCI_DATA_W-1:0] instr_imm_i,
  output logic instr_ready_o,
  input wire logic acc_we_i,
  input wire logic [SCI_DATA_W-1:0] acc_i,
  input wire logic flags_we_i,
  input wire logic [SCI_FLAG_W-1:0] flags_i,
  input wire logic irq_req_i,
  input wire logic wake_i,
  input wire logic [SCI_WORD_W-1:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic [SCI_SP_W-1:0] mem_addr_o,
  output logic [SCI_WORD_W-1:0] mem_wdata_o,
  output logic [PC_W-1:0] pc_o,
  output logic [SCI_SP_W-1:0] sp_o,
  output logic [SCI_DATA_W-1:0] acc_o,
  output logic [SCI_FLAG_W-1:0] flags_o,
  output logic gie_o,
  output logic irq_to_core_o,
  output logic core_clk_en_o,
  output logic osc_en_o,
  output logic chip_reset_o,
  output logic wdt_clear_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (PC_W < 8 || PC_W > SCI_WORD_W)
  begin : g_bad_pc_w
    $error("PC_W must lie between 8 and 16");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sci_state_type state_reg;
  sci_op_type op_reg;
  logic [PC_W-1:0] pc_reg;
  logic [SCI_SP_W-1:0] sp_reg;
  logic [SCI_DATA_W-1:0] acc_reg;
  logic [SCI_FLAG_W-1:0] flags_reg;
  logic gie_reg;
  logic full_halt_reg;
  logic core_halt_reg;
  logic chip_rst_reg;
  logic wdt_clear_reg;
  logic mem_wr_reg;
  logic mem_rd_reg;
  logic [SCI_SP_W-1:0] mem_addr_reg;
  logic [SCI_WORD_W-1:0] mem_wdata_reg;
  logic wake_sync;
  logic accept;
  logic two_cycle;
  logic [PC_W-1:0] pc_inc;
  logic [SCI_SP_W-1:0] sp_down;

  sci_sync2 u_wake_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .async_i(wake_i),
    .sync_o(wake_sync)
  );

  assign instr_ready_o = (state_reg == SCI_ST_RUN);
  assign accept = instr_valid_i && instr_ready_o;
  assign pc_inc = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
  assign sp_down = sp_reg - SCI_SP_STEP;
  assign two_cycle = (instr_op_i == SCI_OP_JUMP) || (instr_op_i == SCI_OP_CALL) ||
                     (instr_op_i == SCI_OP_RET) || (instr_op_i == SCI_OP_RET_IMM) ||
                     (instr_op_i == SCI_OP_ISR_EXIT) || (instr_op_i == SCI_OP_PC_ADD);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= SCI_ST_RUN;
      op_reg <= SCI_OP_IDLE;
    end
    else
    begin
      case (state_reg)
        SCI_ST_RUN:
        begin
          if (accept)
          begin
            op_reg <= instr_op_i;
            if (two_cycle)
            begin
              state_reg <= SCI_ST_SECOND;
            end
            else if (instr_op_i == SCI_OP_FULL_HALT || instr_op_i == SCI_OP_CORE_HALT)
            begin
              state_reg <= SCI_ST_HALT;
            end
            else if (instr_op_i == SCI_OP_CHIP_RST)
            begin
              state_reg <= SCI_ST_RESET;
            end
          end
        end
        SCI_ST_SECOND:
        begin
          state_reg <= SCI_ST_RUN;
        end
        SCI_ST_HALT:
        begin
          if (wake_sync)
          begin
            state_reg <= SCI_ST_RUN;
          end
        end
        SCI_ST_RESET:
        begin
          state_reg <= SCI_ST_RUN;
          op_reg <= SCI_OP_IDLE;
        end
        default:
        begin
          state_reg <= SCI_ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_reg <= '0;
    end
    else if (state_reg == SCI_ST_RESET)
    begin
      pc_reg <= '0;
    end
    else if (state_reg == SCI_ST_SECOND && (op_reg == SCI_OP_RET ||
             op_reg == SCI_OP_RET_IMM || op_reg == SCI_OP_ISR_EXIT))
    begin
      pc_reg <= mem_rdata_i[PC_W-1:0];
    end
    else if (accept)
    begin
      case (instr_op_i)
        SCI_OP_JUMP: pc_reg <= instr_target_i;
        SCI_OP_CALL: pc_reg <= instr_target_i;
        SCI_OP_PC_ADD: pc_reg <= pc_reg + {{(PC_W-SCI_DATA_W){1'b0}}, acc_reg};
        SCI_OP_RET, SCI_OP_RET_IMM, SCI_OP_ISR_EXIT: pc_reg <= pc_reg;
        default: pc_reg <= pc_inc;
      endcase
    end
  end

  // ----------------------------------------
  // Stack pointer and stack memory port
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sp_reg <= SCI_SP_RST;
      mem_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
    end
    else
    begin
      mem_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      if (state_reg == SCI_ST_RESET)
      begin
        sp_reg <= SCI_SP_RST;
        mem_addr_reg <= '0;
        mem_wdata_reg <= '0;
      end
      else if (accept && instr_op_i == SCI_OP_CALL)
      begin
        mem_wr_reg <= 1'b1;
        mem_addr_reg <= sp_reg;
        mem_wdata_reg <= {{(SCI_WORD_W-PC_W){1'b0}}, pc_inc};
        sp_reg <= sp_reg + SCI_SP_STEP;
      end
      else if (accept && (instr_op_i == SCI_OP_RET || instr_op_i == SCI_OP_RET_IMM ||
               instr_op_i == SCI_OP_ISR_EXIT))
      begin
        mem_rd_reg <= 1'b1;
        mem_addr_reg <= sp_down;
        sp_reg <= sp_down;
      end
    end
  end

  // ----------------------------------------
  // Work register and flags
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_reg <= SCI_ACC_RST;
      flags_reg <= SCI_FLAG_RST;
    end
    else if (state_reg == SCI_ST_RESET)
    begin
      acc_reg <= SCI_ACC_RST;
      flags_reg <= SCI_FLAG_RST;
    end
    else
    begin
      if (accept && instr_op_i == SCI_OP_RET_IMM)
      begin
        acc_reg <= instr_imm_i;
      end
      else if (acc_we_i && !accept)
      begin
        acc_reg <= acc_i;
      end
      if (flags_we_i && !accept)
      begin
        flags_reg <= flags_i;
      end
    end
  end

  // ----------------------------------------
  // Global interrupt enable
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gie_reg <= SCI_GIE_RST;
    end
    else if (state_reg == SCI_ST_RESET)
    begin
      gie_reg <= SCI_GIE_RST;
    end
    else if (state_reg == SCI_ST_SECOND && op_reg == SCI_OP_ISR_EXIT)
    begin
      gie_reg <= 1'b1;
    end
    else if (accept && instr_op_i == SCI_OP_IRQ_ON)
    begin
      gie_reg <= 1'b1;
    end
    else if (accept && instr_op_i == SCI_OP_IRQ_OFF)
    begin
      gie_reg <= 1'b0;
    end
  end

  assign irq_to_core_o = irq_req_i && gie_reg;

  // ----------------------------------------
  // Halt, reset and watchdog controls
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      full_halt_reg <= 1'b0;
      core_halt_reg <= 1'b0;
      chip_rst_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
    end
    else
    begin
      chip_rst_reg <= accept && instr_op_i == SCI_OP_CHIP_RST;
      wdt_clear_reg <= accept && instr_op_i == SCI_OP_WDT_KICK;
      if (state_reg == SCI_ST_HALT && wake_sync)
      begin
        full_halt_reg <= 1'b0;
        core_halt_reg <= 1'b0;
      end
      else if (accept && instr_op_i == SCI_OP_FULL_HALT)
      begin
        full_halt_reg <= 1'b1;
      end
      else if (accept && instr_op_i == SCI_OP_CORE_HALT)
      begin
        core_halt_reg <= 1'b1;
      end
    end
  end

  assign core_clk_en_o = !(full_halt_reg || core_halt_reg);
  assign osc_en_o = !full_halt_reg;
  assign chip_reset_o = chip_rst_reg;
  assign wdt_clear_o = wdt_clear_reg;
  assign mem_wr_o = mem_wr_reg;
  assign mem_rd_o = mem_rd_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign acc_o = acc_reg;
  assign flags_o = flags_reg;
  assign gie_o = gie_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_call_taken;
    accept && instr_op_i == SCI_OP_CALL;
  endsequence

  sequence s_ret_taken;
    accept && (instr_op_i == SCI_OP_RET || instr_op_i == SCI_OP_RET_IMM ||
               instr_op_i == SCI_OP_ISR_EXIT);
  endsequence

  a_call_stack_push: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_call_taken |=> mem_wr_o && mem_addr_o == $past(sp_reg) &&
      sp_reg == $past(sp_reg) + SCI_SP_STEP && pc_reg == $past(instr_target_i))
    else $error("call did not push return address and step stack");

  a_jump_target: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_JUMP |=> pc_reg == $past(instr_target_i))
    else $error("jump did not load target");

  a_ret_imm_acc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_RET_IMM |=> acc_reg == $past(instr_imm_i))
    else $error("immediate return did not load work register");

  a_ret_pop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_ret_taken |=> mem_rd_o && sp_reg == $past(sp_reg) - SCI_SP_STEP &&
      mem_addr_o == sp_reg ##1 pc_reg == $past(mem_rdata_i[PC_W-1:0]))
    else $error("return did not pop program counter");

  a_isr_gie: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_ISR_EXIT |=> !instr_ready_o ##1 gie_reg)
    else $error("interrupt return did not set global enable");

  a_pcadd_sum: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_PC_ADD |=>
      pc_reg == $past(pc_reg) + {{(PC_W-SCI_DATA_W){1'b0}}, $past(acc_reg)})
    else $error("computed branch target wrong");

  a_irq_gate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_IRQ_OFF |=> !gie_reg && !irq_to_core_o)
    else $error("interrupt request passed while disabled");

  a_full_halt_osc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_FULL_HALT |=> !osc_en_o && !core_clk_en_o)
    else $error("full halt left clocks running");

  a_core_halt_osc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_CORE_HALT |=> osc_en_o && !core_clk_en_o)
    else $error("core halt wrong clock controls");

  a_chip_reset: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_CHIP_RST |=> chip_reset_o ##1
      pc_reg == '0 && sp_reg == SCI_SP_RST && !gie_reg)
    else $error("chip reset did not restore reset state");

  a_wdt_kick: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_WDT_KICK |=> wdt_clear_o ##1
      (!wdt_clear_o || $past(accept && instr_op_i == SCI_OP_WDT_KICK)))
    else $error("watchdog clear not a single pulse");

  a_flags_kept: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && state_reg == SCI_ST_RUN |=> $stable(flags_reg))
    else $error("system instruction changed flags");

  a_two_cycle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && two_cycle |=> !instr_ready_o ##1 instr_ready_o)
    else $error("two-cycle instruction timing wrong");

  a_idle_step: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    accept && instr_op_i == SCI_OP_IDLE |=> pc_reg == $past(pc_inc) && $stable(sp_reg)
      && $stable(gie_reg) && instr_ready_o)
    else $error("idle op changed state");

  a_wake_resume: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    state_reg == SCI_ST_HALT && wake_sync |=> instr_ready_o && core_clk_en_o &&
      $stable(pc_reg))
    else $error("wake did not resume execution");

endmodule // sci_exec

// *** core/sci_defs.sv ***
// Constants, opcode and state types, and the pin synchroniser of the
// system-control instruction executor.
// Assumes a single 250 MHz clock and an asynchronous active-low reset.

`timescale 1ns/10ps

package sci_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  typedef enum logic [3:0] {
    SCI_OP_IDLE      = 4'h0,
    SCI_OP_JUMP      = 4'h1,
    SCI_OP_CALL      = 4'h2,
    SCI_OP_RET       = 4'h3,
    SCI_OP_RET_IMM   = 4'h4,
    SCI_OP_ISR_EXIT  = 4'h5,
    SCI_OP_PC_ADD    = 4'h6,
    SCI_OP_IRQ_ON    = 4'h7,
    SCI_OP_IRQ_OFF   = 4'h8,
    SCI_OP_FULL_HALT = 4'h9,
    SCI_OP_CORE_HALT = 4'ha,
    SCI_OP_CHIP_RST  = 4'hb,
    SCI_OP_WDT_KICK  = 4'hc
  } sci_op_type;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCI_ST_RUN    = 2'b00,
    SCI_ST_SECOND = 2'b01,
    SCI_ST_HALT   = 2'b10,
    SCI_ST_RESET  = 2'b11
  } sci_state_type;

  // ----------------------------------------
  // Sizes, steps and reset values
  // ----------------------------------------
  localparam int SCI_PC_W_DEF = 12;
  localparam int SCI_SP_W = 8;
  localparam int SCI_DATA_W = 8;
  localparam int SCI_WORD_W = 16;
  localparam int SCI_FLAG_W = 4;
  localparam logic [SCI_SP_W-1:0] SCI_SP_STEP = 8'h02;
  localparam logic [SCI_SP_W-1:0] SCI_SP_RST = 8'h00;
  localparam logic [SCI_DATA_W-1:0] SCI_ACC_RST = 8'h00;
  localparam logic [SCI_FLAG_W-1:0] SCI_FLAG_RST = 4'h0;
  localparam logic SCI_GIE_RST = 1'b0;
  localparam int SCI_SYNC_STAGES = 2;

endpackage

// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module sci_sync2
  import sci_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic sync_o
);

  logic [SCI_SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage_reg <= '0;
    end
    else
    begin
      stage_reg <= {stage_reg[SCI_SYNC_STAGES-2:0], async_i};
    end
  end

  assign sync_o = stage_reg[SCI_SYNC_STAGES-1];

endmodule // sci_sync2

// *** verif/tb_top.sv ***
// Self-checking bench of the system-control instruction executor.
// Assumes the design's own assertions; the bench acts as fetch stage and stack memory.

`timescale 1ns/10ps

module tb_top
  import sci_pkg::*;
;
  localparam int PW = 12;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  sci_op_type instr_op_i = SCI_OP_IDLE;
  logic [PW-1:0] instr_target_i = '0;
  logic [SCI_DATA_W-1:0] instr_imm_i = '0;
  logic acc_we_i = 1'b0;
  logic [SCI_DATA_W-1:0] acc_i = '0;
  logic flags_we_i = 1'b0;
  logic [SCI_FLAG_W-1:0] flags_i = '0;
  logic irq_req_i = 1'b0;
  logic wake_i = 1'b0;
  logic [SCI_WORD_W-1:0] mem_rdata_i;
  logic instr_ready_o, mem_wr_o, mem_rd_o, gie_o, irq_to_core_o;
  logic core_clk_en_o, osc_en_o, chip_reset_o, wdt_clear_o;
  logic [SCI_SP_W-1:0] mem_addr_o, sp_o;
  logic [SCI_WORD_W-1:0] mem_wdata_o;
  logic [PW-1:0] pc_o;
  logic [SCI_DATA_W-1:0] acc_o;
  logic [SCI_FLAG_W-1:0] flags_o;
  logic [SCI_WORD_W-1:0] stk [0:255];
  logic [PW-1:0] exp_pc;
  logic [SCI_SP_W-1:0] exp_sp;
  int error_cnt = 0;
  int check_count = 0;

  sci_exec #(.PC_W(PW)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .instr_target_i(instr_target_i), .instr_imm_i(instr_imm_i),
    .instr_ready_o(instr_ready_o), .acc_we_i(acc_we_i), .acc_i(acc_i),
    .flags_we_i(flags_we_i), .flags_i(flags_i), .irq_req_i(irq_req_i), .wake_i(wake_i),
    .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .sp_o(sp_o),
    .acc_o(acc_o), .flags_o(flags_o), .gie_o(gie_o), .irq_to_core_o(irq_to_core_o),
    .core_clk_en_o(core_clk_en_o), .osc_en_o(osc_en_o), .chip_reset_o(chip_reset_o),
    .wdt_clear_o(wdt_clear_o)
  );

  // ----------------------------------------
  // Clock and stack memory
  // ----------------------------------------
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end

  initial
  begin
    for (int i = 0; i < 256; i++) stk[i] = ~(16'(i));
  end

  always @(posedge mclk_i)
  begin
    if (mem_wr_o === 1'b1) stk[mem_addr_o] <= mem_wdata_o;
  end

  assign mem_rdata_i = stk[mem_addr_o];

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1)
    begin
      if (n == 20)
      begin
        chk(instr_ready_o, 1'b1);
        final_report();
      end
      step();
      n++;
    end
  endtask

  task automatic issue(input sci_op_type op, input logic [PW-1:0] tgt,
                       input logic [SCI_DATA_W-1:0] imm);
    wait_ready();
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    instr_target_i <= tgt;
    instr_imm_i <= imm;
    acc_we_i <= 1'b1;
    acc_i <= 8'h99;
    flags_we_i <= 1'b1;
    flags_i <= 4'ha;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    acc_we_i <= 1'b0;
    flags_we_i <= 1'b0;
    #1;
  endtask

  task automatic set_dp(input logic [SCI_DATA_W-1:0] a, input logic [SCI_FLAG_W-1:0] f);
    @(posedge mclk_i);
    acc_we_i <= 1'b1;
    acc_i <= a;
    flags_we_i <= 1'b1;
    flags_i <= f;
    @(posedge mclk_i);
    acc_we_i <= 1'b0;
    flags_we_i <= 1'b0;
    #1;
  endtask

  task automatic jump(input logic [PW-1:0] tgt);
    issue(SCI_OP_JUMP, tgt, 8'h00);
    chk(pc_o, tgt);
    chk(instr_ready_o, 1'b0);
    exp_pc = tgt;
  endtask

  task automatic do_call(input logic [PW-1:0] tgt);
    issue(SCI_OP_CALL, tgt, 8'h00);
    chk(pc_o, tgt);
    chk(sp_o, exp_sp + 8'h02);
    chk(mem_wr_o, 1'b1);
    chk(mem_addr_o, exp_sp);
    chk(mem_wdata_o, exp_pc + 1);
    chk(instr_ready_o, 1'b0);
    step();
    chk(mem_wr_o, 1'b0);
    chk(instr_ready_o, 1'b1);
    chk(flags_o, 4'h5);
    exp_sp = exp_sp + 8'h02;
    exp_pc = tgt;
  endtask

  task automatic do_ret(input sci_op_type op, input logic [SCI_DATA_W-1:0] imm,
                        input logic [PW-1:0] ret_pc);
    issue(op, 12'h000, imm);
    exp_sp = exp_sp - 8'h02;
    chk(sp_o, exp_sp);
    chk(mem_rd_o, 1'b1);
    chk(mem_addr_o, exp_sp);
    chk(instr_ready_o, 1'b0);
    if (op == SCI_OP_RET_IMM) chk(acc_o, imm);
    step();
    chk(pc_o, ret_pc);
    chk(mem_rd_o, 1'b0);
    chk(instr_ready_o, 1'b1);
    chk(flags_o, 4'h5);
    exp_pc = ret_pc;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    chk({pc_o, sp_o, acc_o}, 28'h0);
    chk({flags_o, gie_o}, 5'h0);
    chk({instr_ready_o, core_clk_en_o, osc_en_o}, 3'h7);
    chk({mem_wr_o, mem_rd_o, chip_reset_o, wdt_clear_o}, 4'h0);
  endtask

  task automatic t_idle_jump();
    set_dp(8'hfe, 4'h5);
    issue(SCI_OP_IDLE, 12'hfff, 8'h00);
    chk(pc_o, 12'h001);
    chk({sp_o, acc_o, flags_o, mem_wr_o}, {8'h00, 8'hfe, 4'h5, 1'b0});
    chk(instr_ready_o, 1'b1);
    jump(12'h123);
    step();
    chk(instr_ready_o, 1'b1);
  endtask

  task automatic t_calls();
    do_call(12'h400);
    do_call(12'h800);
    do_ret(SCI_OP_RET, 8'h00, 12'h401);
    do_ret(SCI_OP_RET, 8'h00, 12'h124);
    do_call(12'h0f0);
    do_ret(SCI_OP_RET_IMM, 8'h5a, 12'h125);
  endtask

  task automatic t_pcadd();
    set_dp(8'hfe, 4'h5);
    issue(SCI_OP_PC_ADD, 12'h000, 8'h00);
    chk(pc_o, 12'h223);
    chk(instr_ready_o, 1'b0);
    chk(flags_o, 4'h5);
  endtask

  task automatic t_irq();
    @(posedge mclk_i);
    irq_req_i <= 1'b1;
    issue(SCI_OP_IRQ_OFF, 12'h000, 8'h00);
    chk({gie_o, irq_to_core_o}, 2'b00);
    issue(SCI_OP_IRQ_ON, 12'h000, 8'h00);
    chk({gie_o, irq_to_core_o}, 2'b11);
    issue(SCI_OP_IRQ_OFF, 12'h000, 8'h00);
    chk({gie_o, irq_to_core_o}, 2'b00);
    jump(12'h300);
    do_call(12'h500);
    do_ret(SCI_OP_ISR_EXIT, 8'h00, 12'h301);
    chk({gie_o, irq_to_core_o}, 2'b11);
    chk(flags_o, 4'h5);
  endtask

  task automatic t_wdt();
    issue(SCI_OP_WDT_KICK, 12'h000, 8'h00);
    chk({wdt_clear_o, chip_reset_o}, 2'b10);
    step();
    chk(wdt_clear_o, 1'b0);
  endtask

  task automatic t_halt(input sci_op_type op, input logic osc_exp);
    int n;
    jump(12'h600);
    issue(op, 12'h000, 8'h00);
    chk(pc_o, 12'h601);
    chk({core_clk_en_o, osc_en_o}, {1'b0, osc_exp});
    repeat (4) step();
    chk({instr_ready_o, core_clk_en_o}, 2'b00);
    @(posedge mclk_i);
    wake_i <= 1'b1;
    n = 0;
    while (instr_ready_o !== 1'b1)
    begin
      if (n == 10)
      begin
        chk(instr_ready_o, 1'b1);
        final_report();
      end
      step();
      n++;
    end
    chk({pc_o, core_clk_en_o, osc_en_o}, {12'h601, 2'b11});
    @(posedge mclk_i);
    wake_i <= 1'b0;
    repeat (3) step();
    issue(SCI_OP_IDLE, 12'h000, 8'h00);
    chk(pc_o, 12'h602);
    exp_pc = 12'h602;
  endtask

  task automatic t_chip_rst();
    do_call(12'h700);
    set_dp(8'h77, 4'h9);
    issue(SCI_OP_IRQ_ON, 12'h000, 8'h00);
    issue(SCI_OP_CHIP_RST, 12'h000, 8'h00);
    chk({chip_reset_o, instr_ready_o}, 2'b10);
    step();
    chk({pc_o, sp_o, acc_o}, 28'h0);
    chk({flags_o, gie_o}, 5'h0);
    chk({mem_addr_o, mem_wdata_o}, 24'h0);
    chk({chip_reset_o, instr_ready_o}, 2'b01);
  endtask

  task automatic t_hw_rst();
    issue(SCI_OP_IRQ_ON, 12'h000, 8'h00);
    set_dp(8'h3c, 4'h6);
    jump(12'h0aa);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    step();
    chk({pc_o, sp_o, acc_o}, 28'h0);
    chk({flags_o, gie_o, instr_ready_o}, 6'h01);
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1;
    issue(SCI_OP_IDLE, 12'h000, 8'h00);
    chk(pc_o, 12'h001);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    exp_pc = '0;
    exp_sp = '0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1;
    t_reset_vals();
    t_idle_jump();
    t_calls();
    t_pcadd();
    t_irq();
    t_wdt();
    t_halt(SCI_OP_FULL_HALT, 1'b0);
    t_halt(SCI_OP_CORE_HALT, 1'b1);
    t_chip_rst();
    t_hw_rst();
    final_report();
  end

endmodule // tb_top
